// [common/fpv_regs.vh]
`ifndef FPV_REGS_VH
`define FPV_REGS_VH
// ====================================================================
// Opcodes
`define FPV_OP_PROG_ERASE_B1 8'h83
`define FPV_OP_PROG_ERASE_B2 8'h86
`define FPV_OP_PROG_ONLY_B1  8'h88
`define FPV_OP_PROG_ONLY_B2  8'h89
`define FPV_OP_THRU_BUF_B1   8'h82
`define FPV_OP_THRU_BUF_B2   8'h85
`define FPV_OP_COMPARE_B1    8'h60
`define FPV_OP_COMPARE_B2    8'h61
`define FPV_OP_STATUS_READ   8'hD7
// ====================================================================
// Status fields
`define FPV_ST_READY_BIT     7
`define FPV_ST_COMPARE_BIT   6
`define FPV_ST_RESET         8'h80
// ====================================================================
// Geometry and timing
`define FPV_PAGE_BYTES       264
`define FPV_PAGE_AW          9
`define FPV_NUM_PAGES        16
`define FPV_PAGE_IW          4
`define FPV_CLK_MHZ          250
`define FPV_ERASE_PROG_MS    35
`define FPV_ERASE_PROG_L_MS  40
`define FPV_ERASE_PROG_U_MS  55
`define FPV_PROG_ONLY_MS     4
`define FPV_PROG_ONLY_L_MS   6
`define FPV_COMPARE_US       400
`define FPV_COMPARE_CYC      (`FPV_COMPARE_US * `FPV_CLK_MHZ)
`endif

// [core/fpv_fifo.v]
`timescale 1ns/1ps
module fpv_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ff;
  reg [AW:0]      rd_ff;
  wire            full;
  wire            empty;
  assign full      = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign empty     = (wr_ff == rd_ff);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ff[AW-1:0]];
  always @(posedge clk)
  begin
    if (in_valid && !full)
      mem[wr_ff[AW-1:0]] <= in_data;
  end
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_ff <= {(AW+1){1'b0}};
      rd_ff <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
        wr_ff <= wr_ff + 1'b1;
      if (out_ready && !empty)
        rd_ff <= rd_ff + 1'b1;
    end
  end
endmodule // fpv_fifo

// [core/fpv_sequencer.v]
`timescale 1ns/1ps
`include "fpv_regs.vh"
module fpv_sequencer #(
  parameter [31:0] ERASE_PROG_CYC = `FPV_ERASE_PROG_MS * 1000 * `FPV_CLK_MHZ,
  parameter [31:0] PROG_ONLY_CYC  = `FPV_PROG_ONLY_MS * 1000 * `FPV_CLK_MHZ,
  parameter [31:0] COMPARE_CYC    = `FPV_COMPARE_CYC,
  parameter        SINGLE_BUFFER  = 0
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       select_low_n,
  input  wire       sclk,
  input  wire       mosi,
  output reg        miso_ff,
  output wire [7:0] status,
  output wire       busy
);
  // ==================================================================
  // Pin synchronisers
  reg [1:0] sel_sync_ff;
  reg [1:0] clk_sync_ff;
  reg [1:0] mosi_sync_ff;
  reg       sel_prev_ff;
  reg       clk_prev_ff;
  wire      sel_n_s = sel_sync_ff[1];
  wire      sclk_s  = clk_sync_ff[1];
  wire      mosi_s  = mosi_sync_ff[1];
  wire      sclk_rise = sclk_s && !clk_prev_ff;
  wire      sclk_fall = !sclk_s && clk_prev_ff;
  wire      sel_start = !sel_n_s && sel_prev_ff;
  wire      sel_end   = sel_n_s && !sel_prev_ff;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Link clock idles high, so a low reset value would fake an edge
      sel_sync_ff  <= 2'h3;
      clk_sync_ff  <= 2'h3;
      mosi_sync_ff <= 2'h0;
      sel_prev_ff  <= 1'b1;
      clk_prev_ff  <= 1'b1;
    end
    else
    begin
      sel_sync_ff  <= {sel_sync_ff[0], select_low_n};
      clk_sync_ff  <= {clk_sync_ff[0], sclk};
      mosi_sync_ff <= {mosi_sync_ff[0], mosi};
      sel_prev_ff  <= sel_n_s;
      clk_prev_ff  <= sclk_s;
    end
  end

  // ==================================================================
  // Opcode decode
  function [2:0] op_kind;
    input [7:0] op;
    begin
      case (op)
        `FPV_OP_PROG_ERASE_B1, `FPV_OP_PROG_ERASE_B2: op_kind = 3'h1;
        `FPV_OP_PROG_ONLY_B1,  `FPV_OP_PROG_ONLY_B2:  op_kind = 3'h2;
        `FPV_OP_THRU_BUF_B1,   `FPV_OP_THRU_BUF_B2:   op_kind = 3'h3;
        `FPV_OP_COMPARE_B1,    `FPV_OP_COMPARE_B2:    op_kind = 3'h4;
        `FPV_OP_STATUS_READ:                          op_kind = 3'h5;
        default:                                      op_kind = 3'h0;
      endcase
    end
  endfunction

  function op_second_buf;
    input [7:0] op;
    begin
      op_second_buf = (op == `FPV_OP_PROG_ERASE_B2) || (op == `FPV_OP_PROG_ONLY_B2) ||
                      (op == `FPV_OP_THRU_BUF_B2) || (op == `FPV_OP_COMPARE_B2);
    end
  endfunction

  // ==================================================================
  // Serial shifter, sampled on link rising edges
  reg [5:0]  bit_cnt_ff;
  reg [7:0]  shift_ff;
  reg [7:0]  opcode_ff;
  reg [23:0] addr_ff;
  reg        byte_done_ff;
  reg [7:0]  byte_ff;
  wire [7:0] shift_next = {shift_ff[6:0], mosi_s};

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      bit_cnt_ff   <= 6'h00;
      shift_ff     <= 8'h00;
      opcode_ff    <= 8'h00;
      addr_ff      <= 24'h000000;
      byte_done_ff <= 1'b0;
      byte_ff      <= 8'h00;
    end
    else
    begin
      byte_done_ff <= 1'b0;
      if (sel_start)
        bit_cnt_ff <= 6'h00;
      else if (!sel_n_s && sclk_rise)
      begin
        shift_ff <= shift_next;
        if (bit_cnt_ff == 6'h07)
          opcode_ff <= shift_next;
        if (bit_cnt_ff >= 6'h08 && bit_cnt_ff < 6'h20)
          addr_ff <= {addr_ff[22:0], mosi_s};
        if (bit_cnt_ff[2:0] == 3'h7 && bit_cnt_ff >= 6'h27)
        begin
          byte_done_ff <= 1'b1;
          byte_ff      <= shift_next;
        end
        if (bit_cnt_ff < 6'h27)
          bit_cnt_ff <= bit_cnt_ff + 6'h01;
        else
          bit_cnt_ff <= (bit_cnt_ff == 6'h2F) ? 6'h28 : bit_cnt_ff + 6'h01;
      end
    end
  end

  // ==================================================================
  // Write data stream through the FIFO
  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire       fifo_pop;

  fpv_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .AW    (3)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (byte_done_ff && op_kind(opcode_ff) == 3'h3),
    .in_ready  (),
    .in_data   (byte_ff),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ==================================================================
  // Page buffers and flash array
  // Buffer 2 starts at 512, so the index is a plain {buffer, byte}
  reg [7:0] buf_mem  [0:1023];
  reg [7:0] page_mem [0:`FPV_NUM_PAGES*`FPV_PAGE_BYTES-1];
  reg [8:0] wr_ptr_ff;
  reg       wr_buf_ff;

  localparam S_IDLE   = 5'h01;
  localparam S_ERASE  = 5'h02;
  localparam S_PROG   = 5'h04;
  localparam S_CMP    = 5'h08;
  localparam S_WAIT   = 5'h10;

  reg [4:0]  state_ff;
  reg [31:0] timer_ff;
  reg [8:0]  idx_ff;
  reg        op_buf_ff;
  reg [3:0]  op_page_ff;
  reg        mismatch_ff;
  reg        ready_ff;
  reg        compare_ff;
  reg        cmp_op_ff;

  wire [3:0] cmd_page = addr_ff[`FPV_PAGE_IW+8:9];
  wire [9:0] buf_idx  = {op_buf_ff, idx_ff};
  wire [31:0] pg_full = op_page_ff * `FPV_PAGE_BYTES + idx_ff;
  wire [12:0] pg_idx  = pg_full[12:0];
  wire        last_idx = (idx_ff == `FPV_PAGE_BYTES - 1);
  wire [2:0]  kind     = op_kind(opcode_ff);
  // Second-buffer forms dropped on the single-buffer build
  wire        cmd_ok   = !(SINGLE_BUFFER && op_second_buf(opcode_ff));
  wire        cmd_accept = (state_ff == S_IDLE) && sel_end && (bit_cnt_ff >= 6'h20) && cmd_ok &&
                           (kind != 3'h0) && (kind != 3'h5);
  // Buffer writes drain only while idle, so the FIFO really stalls
  assign fifo_pop = fifo_valid && (state_ff == S_IDLE);

  always @(posedge clk)
  begin
    if (fifo_pop)
      buf_mem[{wr_buf_ff, wr_ptr_ff}] <= fifo_data;
    if (state_ff == S_ERASE)
      page_mem[pg_idx] <= 8'hFF;
    else if (state_ff == S_PROG)
      page_mem[pg_idx] <= page_mem[pg_idx] & buf_mem[buf_idx];
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff         <= S_IDLE;
      timer_ff         <= 32'h00000000;
      idx_ff           <= 9'h000;
      op_buf_ff        <= 1'b0;
      op_page_ff       <= 4'h0;
      mismatch_ff      <= 1'b0;
      ready_ff         <= 1'b1;
      compare_ff       <= 1'b0;
      wr_ptr_ff        <= 9'h000;
      wr_buf_ff        <= 1'b0;
    end
    else
    begin
      if (!sel_n_s && bit_cnt_ff == 6'h20 && sclk_fall && kind == 3'h3)
      begin
        wr_ptr_ff <= (addr_ff[8:0] >= `FPV_PAGE_BYTES) ? 9'h000 : addr_ff[8:0];
        wr_buf_ff <= op_second_buf(opcode_ff);
      end
      else if (fifo_pop)
        wr_ptr_ff <= (wr_ptr_ff == `FPV_PAGE_BYTES - 1) ? 9'h000 : wr_ptr_ff + 9'h001;
      case (state_ff)
        S_IDLE:
        begin
          // Command only counts if select stayed low through the address
          if (cmd_accept)
          begin
            op_buf_ff  <= op_second_buf(opcode_ff);
            op_page_ff <= cmd_page;
            idx_ff     <= 9'h000;
            ready_ff   <= 1'b0;
            mismatch_ff <= 1'b0;
            if (kind == 3'h4)
            begin
              state_ff <= S_CMP;
              timer_ff <= COMPARE_CYC;
            end
            else if (kind == 3'h2)
            begin
              state_ff <= S_PROG;
              timer_ff <= PROG_ONLY_CYC;
            end
            else
            begin
              state_ff <= S_ERASE;
              timer_ff <= ERASE_PROG_CYC;
            end
          end
        end
        S_ERASE:
        begin
          timer_ff <= timer_ff - 32'h00000001;
          idx_ff   <= last_idx ? 9'h000 : idx_ff + 9'h001;
          if (last_idx)
            state_ff <= S_PROG;
        end
        S_PROG:
        begin
          timer_ff <= timer_ff - 32'h00000001;
          idx_ff   <= idx_ff + 9'h001;
          if (last_idx)
            state_ff <= S_WAIT;
        end
        S_CMP:
        begin
          timer_ff <= timer_ff - 32'h00000001;
          idx_ff   <= idx_ff + 9'h001;
          if (page_mem[pg_idx] != buf_mem[buf_idx])
            mismatch_ff <= 1'b1;
          if (last_idx)
            state_ff <= S_WAIT;
        end
        S_WAIT:
        begin
          // Hold busy for the full timed budget, not just the copy loop
          if (timer_ff <= 32'h00000001)
          begin
            state_ff <= S_IDLE;
            ready_ff <= 1'b1;
            // Flag moves with ready, so a poll never sees a stale result
            if (cmp_op_ff)
              compare_ff <= mismatch_ff;
          end
          else
            timer_ff <= timer_ff - 32'h00000001;
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

  // Compare result is only latched for a compare operation
  // Opcode may be overwritten by a status poll while busy, so latch the kind
  always @(posedge clk)
  begin
    if (!rst_n)
      cmp_op_ff <= 1'b0;
    else if (cmd_accept)
      cmp_op_ff <= (kind == 3'h4);
  end

  // ==================================================================
  // Status readback on the link
  reg [2:0] st_bit_ff;
  assign status = {ready_ff, compare_ff, 6'h00};
  assign busy   = !ready_ff;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      miso_ff   <= 1'b0;
      st_bit_ff <= 3'h7;
    end
    else if (sel_n_s)
    begin
      miso_ff   <= 1'b0;
      st_bit_ff <= 3'h7;
    end
    else if (sclk_fall && kind == 3'h5 && bit_cnt_ff >= 6'h08)
    begin
      miso_ff   <= status[st_bit_ff];
      st_bit_ff <= st_bit_ff - 3'h1;
    end
  end
endmodule // fpv_sequencer

// [dv/fpv_mst.sv]
`timescale 1ns/1ps
module fpv_mst (
  output logic select_low_n,
  output logic sclk,
  output logic mosi,
  input  wire  miso
);
  // ====
  // Link master; sclk rests high between frames
  localparam int HALF = 32;
  initial
  begin
    select_low_n = 1'b1;
    sclk         = 1'b1;
    mosi         = 1'b0;
  end
  task automatic begin_f();
    select_low_n = 1'b0;
    #HALF;
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = b[i];
      #HALF;
      sclk = 1'b1;
      #HALF;
    end
  endtask
  task automatic get(output logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = ~mosi;
      #HALF;
      sclk = 1'b1;
      b[i] = miso;
      #HALF;
    end
  endtask
  task automatic end_f();
    sclk         = 1'b0;
    select_low_n = 1'b1;
    mosi         = ~mosi;
    #HALF;
    sclk = 1'b1;
    #HALF;
  endtask
endmodule // fpv_mst

// [dv/fpv_seq_asserts.sv]
`timescale 1ns/1ps
module fpv_seq_asserts #(
  parameter [31:0] ERASE_PROG_CYC = 32'h258,
  parameter [31:0] PROG_ONLY_CYC  = 32'h190,
  parameter [31:0] COMPARE_CYC    = 32'h12C
) (
  input wire       clk,
  input wire       rst_n,
  input wire       select_low_n,
  input wire       sclk,
  input wire       mosi,
  input wire       miso_ff,
  input wire [7:0] status,
  input wire       busy
);
  // ====
  // Busy run length; slack covers the select synchroniser
  localparam [31:0] LO = (PROG_ONLY_CYC < COMPARE_CYC ? PROG_ONLY_CYC : COMPARE_CYC) - 32'h2;
  localparam [31:0] HI = ERASE_PROG_CYC + 32'h10;
  logic [31:0] run_ff;
  wire  [31:0] nxt_run = busy ? run_ff + 32'h1 : 32'h0;
  always @(posedge clk) run_ff <= rst_n ? nxt_run : 32'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hold; busy [*8]; endsequence
  sequence s_done; !busy && $past(busy); endsequence
  property p_mirror; busy == !status[7]; endproperty
  property p_start; !select_low_n |=> !$rose(busy); endproperty
  property p_max; run_ff <= HI; endproperty
  property p_min; $fell(busy) |-> run_ff >= LO; endproperty
  property p_low; status[5:0] == 6'h00; endproperty
  property p_cmp; $changed(status[6]) |-> s_done; endproperty
  property p_rst; $rose(rst_n) |-> status == 8'h80 && !busy; endproperty
  property p_hold; $rose(busy) |-> s_hold; endproperty
  a_mirror: assert property (p_mirror) else $error("busy differs from ready");
  a_start: assert property (p_start) else $error("busy rose while selected");
  a_max: assert property (p_max) else $error("busy too long");
  a_min: assert property (p_min) else $error("busy too short");
  a_low: assert property (p_low) else $error("status low bits set");
  a_cmp: assert property (p_cmp) else $error("compare flag moved early");
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_hold: assert property (p_hold) else $error("busy pulse too short");
endmodule // fpv_seq_asserts
bind fpv_sequencer fpv_seq_asserts #(
  .ERASE_PROG_CYC(ERASE_PROG_CYC), .PROG_ONLY_CYC(PROG_ONLY_CYC), .COMPARE_CYC(COMPARE_CYC)
) u_fpv_seq_asserts (.clk(clk), .rst_n(rst_n), .select_low_n(select_low_n), .sclk(sclk),
  .mosi(mosi), .miso_ff(miso_ff), .status(status), .busy(busy));

// [dv/test_flash_page_program_verify.sv]
`timescale 1ns/1ps
`include "fpv_regs.vh"
module test_flash_page_program_verify;
  // ====
  // Short budgets; larger parts raise both EP and PO
  localparam [31:0] EP = 32'h258;
  localparam [31:0] PO = 32'h190;
  localparam [31:0] CP = 32'h12C;
  logic       clk = 1'b0, rst_n = 1'b0, cmp_exp = 1'b0;
  wire        select_low_n, sclk, mosi, miso_ff, busy, busy_1b;
  wire  [7:0] status;
  int         n_errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  fpv_sequencer #(.ERASE_PROG_CYC(EP), .PROG_ONLY_CYC(PO), .COMPARE_CYC(CP)) u_fpv_sequencer (
    .clk(clk), .rst_n(rst_n), .select_low_n(select_low_n), .sclk(sclk), .mosi(mosi),
    .miso_ff(miso_ff), .status(status), .busy(busy));
  fpv_sequencer #(.ERASE_PROG_CYC(EP), .PROG_ONLY_CYC(PO), .COMPARE_CYC(CP), .SINGLE_BUFFER(1))
    u_fpv_sequencer_1b (.clk(clk), .rst_n(rst_n), .select_low_n(select_low_n), .sclk(sclk),
    .mosi(mosi), .miso_ff(), .status(), .busy(busy_1b));
  fpv_mst u_fpv_mst (.select_low_n(select_low_n), .sclk(sclk), .mosi(mosi), .miso(miso_ff));
  // ====
  // Checking
  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_range(input string nm, input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One command frame, busy timing, then a status poll over the link
  task automatic run_op(input logic [7:0] op, input logic [3:0] pg, input logic [8:0] st,
    input int n, input logic [7:0] v, input logic [31:0] cyc, input logic b2);
    logic [23:0] a;
    logic [7:0]  s;
    int          cnt;
    a = {11'h000, pg, st};
    u_fpv_mst.begin_f();
    u_fpv_mst.put(op);
    u_fpv_mst.put(a[23:16]);
    u_fpv_mst.put(a[15:8]);
    u_fpv_mst.put(a[7:0]);
    repeat (n) u_fpv_mst.put(v);
    check8("busy_in_frame", 8'h00, {7'h00, busy});
    u_fpv_mst.end_f();
    check8("busy_started", 8'h01, {7'h00, busy});
    check8("busy_single", {7'h00, ~b2}, {7'h00, busy_1b});
    cnt = 16;
    while (busy === 1'b1 && cnt < cyc + 40)
    begin
      @(negedge clk);
      cnt++;
    end
    check_range("busy_cycles", int'(cyc), int'(cyc) + 16, cnt);
    if (cnt >= cyc + 40) tally_and_finish();
    repeat (4) @(negedge clk);
    u_fpv_mst.begin_f();
    u_fpv_mst.put(`FPV_OP_STATUS_READ);
    u_fpv_mst.get(s);
    u_fpv_mst.end_f();
    check8("status_link", {1'b1, cmp_exp, 6'h00}, s);
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    check8("status_rst", `FPV_ST_RESET, status);
    check8("busy_rst", 8'h00, {7'h00, busy});
    $display("t_reset done");
  endtask
  task automatic t_abort();
    u_fpv_mst.begin_f();
    u_fpv_mst.put(`FPV_OP_PROG_ERASE_B1);
    u_fpv_mst.put(8'h00);
    u_fpv_mst.end_f();
    repeat (8) @(negedge clk);
    check8("busy_abort", 8'h00, {7'h00, busy});
    $display("t_abort done");
  endtask
  // Page 1 stays all ones; the page 2 write wraps into bytes 0 and 1
  task automatic t_wrap();
    run_op(`FPV_OP_THRU_BUF_B1, 4'h1, 9'h000, 264, 8'hFF, EP, 0);
    run_op(`FPV_OP_COMPARE_B1, 4'h1, 9'h0A5, 0, 8'h00, CP, 0);
    run_op(`FPV_OP_THRU_BUF_B1, 4'h2, 9'h106, 4, 8'h00, EP, 0);
    run_op(`FPV_OP_THRU_BUF_B1, 4'h3, 9'h106, 2, 8'hFF, EP, 0);
    cmp_exp = 1'b1;
    run_op(`FPV_OP_COMPARE_B1, 4'h1, 9'h000, 0, 8'h00, CP, 0);
    cmp_exp = 1'b0;
    run_op(`FPV_OP_COMPARE_B1, 4'h3, 9'h000, 0, 8'h00, CP, 0);
    $display("t_wrap done");
  endtask
  task automatic t_buf2();
    run_op(`FPV_OP_THRU_BUF_B2, 4'h5, 9'h000, 264, 8'h00, EP, 1);
    cmp_exp = 1'b1;
    run_op(`FPV_OP_COMPARE_B2, 4'h1, 9'h000, 0, 8'h00, CP, 1);
    run_op(`FPV_OP_PROG_ERASE_B2, 4'h1, 9'h000, 0, 8'h00, EP, 1);
    cmp_exp = 1'b0;
    run_op(`FPV_OP_COMPARE_B2, 4'h1, 9'h000, 0, 8'h00, CP, 1);
    run_op(`FPV_OP_PROG_ONLY_B2, 4'h2, 9'h000, 0, 8'h00, PO, 1);
    run_op(`FPV_OP_COMPARE_B2, 4'h2, 9'h000, 0, 8'h00, CP, 1);
    $display("t_buf2 done");
  endtask
  // Programming without erase leaves page 5 at zero, so it differs
  task automatic t_prog();
    run_op(`FPV_OP_PROG_ONLY_B1, 4'h5, 9'h000, 0, 8'h00, PO, 0);
    cmp_exp = 1'b1;
    run_op(`FPV_OP_COMPARE_B1, 4'h5, 9'h000, 0, 8'h00, CP, 0);
    run_op(`FPV_OP_PROG_ERASE_B1, 4'h5, 9'h000, 0, 8'h00, EP, 0);
    cmp_exp = 1'b0;
    run_op(`FPV_OP_COMPARE_B1, 4'h5, 9'h000, 0, 8'h00, CP, 0);
    $display("t_prog done");
  endtask
  // Eight bytes through the write FIFO mid-buffer; page 5 then no longer matches
  task automatic t_fifo();
    run_op(`FPV_OP_THRU_BUF_B1, 4'h6, 9'h0FC, 8, 8'h00, EP, 0);
    cmp_exp = 1'b1;
    run_op(`FPV_OP_COMPARE_B1, 4'h5, 9'h000, 0, 8'h00, CP, 0);
    cmp_exp = 1'b0;
    run_op(`FPV_OP_COMPARE_B1, 4'h6, 9'h000, 0, 8'h00, CP, 0);
    $display("t_fifo done");
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_abort();
    t_wrap();
    t_buf2();
    t_prog();
    t_fifo();
    tally_and_finish();
  end
endmodule // test_flash_page_program_verify
